//--- fcs_sequencer.sv
// Flash command sequencer: takes command words, runs serial flash
// traffic and writes results to memory, display list and status ports.
// Assumes a byte memory with one-cycle read latency and a mode-0 flash.
//
// Summary of operation
// - Blank program copies memory to flash pages
// - Flash read copies flash into main memory
// - Append copies flash into display list
// - Update compares, then erases sectors and writes only if different
// - Detach floats all flash lines
// - Detached: only raw and attach commands
// - Attach reconnects and reports basic state
// - Full-speed switch writes zero on success
// - Full-speed failure writes its error code
// - Full-speed needs valid image in sector zero
// - Raw deselect raises chip select
// - Raw transmit shifts out inline bytes
// - Raw receive stores bytes into main memory
// - Cache clear faults unless display list empty
// - Source command latches flash source address
// - Video start reads header at source address
`timescale 1ns/1ps
`include "fcs_defines.svh"
module fcs_sequencer (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CMD_VALID_IN,
  input  wire logic [31:0] CMD_DATA_IN,
  output logic             CMD_READY_OUT,
  output logic             CMD_DONE_OUT,
  output logic             SPI_SCLK_OUT,
  output logic             SPI_CS_N_OUT,
  output logic             SPI_MOSI_OUT,
  output logic             SPI_OE_OUT,
  input  wire logic        SPI_MISO_IN,
  output logic [31:0]      MEM_ADDR_OUT,
  output logic             MEM_RE_OUT,
  output logic             MEM_WE_OUT,
  input  wire logic [7:0]  MEM_RDATA_IN,
  output logic [7:0]       RX_BYTE_OUT,
  output logic             DL_WE_OUT,
  input  wire logic        DL_EMPTY_IN,
  output logic             VHDR_VALID_OUT,
  output logic             RESULT_WE_OUT,
  output logic [31:0]      RESULT_OUT,
  output logic             CACHE_CLR_OUT,
  output logic             FAULT_OUT,
  output logic             PCLK_ZERO_OUT,
  output logic [1:0]       FLASH_STATE_OUT,
  output logic [31:0]      SRC_PTR_OUT
);
  fcs_pkg::fcs_state_t r;
  fcs_pkg::fcs_state_t nx;

  // Command word to operation
  function automatic fcs_pkg::fcs_op_t op_of(input logic [31:0] c);
    case (c)
      `FCS_C_PROG: op_of = fcs_pkg::OP_PROG;
      `FCS_C_READ: op_of = fcs_pkg::OP_READ;
      `FCS_C_APND: op_of = fcs_pkg::OP_APND;
      `FCS_C_UPD:  op_of = fcs_pkg::OP_UPD;
      `FCS_C_DET:  op_of = fcs_pkg::OP_DET;
      `FCS_C_ATT:  op_of = fcs_pkg::OP_ATT;
      `FCS_C_FAST: op_of = fcs_pkg::OP_FAST;
      `FCS_C_DSEL: op_of = fcs_pkg::OP_DSEL;
      `FCS_C_TX:   op_of = fcs_pkg::OP_TX;
      `FCS_C_RX:   op_of = fcs_pkg::OP_RX;
      `FCS_C_CLR:  op_of = fcs_pkg::OP_CLR;
      `FCS_C_SRC:  op_of = fcs_pkg::OP_SRC;
      `FCS_C_VID:  op_of = fcs_pkg::OP_VID;
      default:     op_of = fcs_pkg::OP_NONE;
    endcase
  endfunction : op_of

  // Parameter words following each command word
  function automatic logic [1:0] need_of(input fcs_pkg::fcs_op_t o);
    case (o)
      fcs_pkg::OP_PROG, fcs_pkg::OP_READ, fcs_pkg::OP_UPD: need_of = 2'h3;
      fcs_pkg::OP_APND, fcs_pkg::OP_RX:                    need_of = 2'h2;
      fcs_pkg::OP_FAST, fcs_pkg::OP_TX, fcs_pkg::OP_SRC:   need_of = 2'h1;
      default:                                             need_of = 2'h0;
    endcase
  endfunction : need_of

  // Operations still legal while the flash is detached
  function automatic logic det_ok(input fcs_pkg::fcs_op_t o);
    det_ok = o == fcs_pkg::OP_DSEL || o == fcs_pkg::OP_TX ||
             o == fcs_pkg::OP_RX || o == fcs_pkg::OP_ATT;
  endfunction : det_ok

  // Starts one chip-select framed transfer: header bytes, then data
  function automatic fcs_pkg::fcs_state_t xfer(
    input fcs_pkg::fcs_state_t s, input logic [31:0] h,
    input logic [2:0] hc, input logic [31:0] n,
    input fcs_pkg::fcs_snk_t k, input fcs_pkg::fcs_src_t q,
    input fcs_pkg::fcs_ph_t ph);
    xfer      = s;
    xfer.hdr  = h;
    xfer.hc   = hc;
    xfer.n    = n;
    xfer.snk  = k;
    xfer.src  = q;
    xfer.ph   = ph;
    xfer.dat  = 1'b0;
    xfer.hold = 1'b0;
    xfer.csn  = 1'b0;
    xfer.st   = fcs_pkg::S_NEXT;
  endfunction : xfer

  // Next-state logic; pulses drop back to zero every cycle
  always_comb
  begin
    nx = r;
    {nx.re, nx.we, nx.dlwe, nx.vhv, nx.rwe} = 5'h00;
    {nx.done, nx.clr, nx.flt, nx.pz} = 4'h0;
    case (r.st)
      fcs_pkg::S_IDLE:
        if (CMD_VALID_IN)
        begin
          nx.op = op_of(CMD_DATA_IN);
          nx.need = need_of(nx.op);
          nx.pc = 2'h0;
          nx.ph = fcs_pkg::PH_NONE;
          if (nx.op == fcs_pkg::OP_NONE ||
              (r.fst == `FCS_FS_DET && !det_ok(nx.op)))
            nx.st = fcs_pkg::S_FIN;
          else if (nx.need == 2'h0)
            nx.st = fcs_pkg::S_DISP;
          else
            nx.st = fcs_pkg::S_PARAM;
        end
      fcs_pkg::S_PARAM:
        if (CMD_VALID_IN)
        begin
          nx.p[r.pc] = CMD_DATA_IN;
          nx.pc = r.pc + 2'h1;
          if (nx.pc == r.need)
            nx.st = fcs_pkg::S_DISP;
        end
      fcs_pkg::S_DISP:
      begin
        nx.st = fcs_pkg::S_FIN;
        case (r.op)
          fcs_pkg::OP_PROG:
          begin
            nx.faddr = r.p[0];
            nx.maddr = r.p[1];
            nx.rem = r.p[2];
            if (r.p[2] != `FCS_N_NONE)
              nx = xfer(nx, {`FCS_F_WREN, `FCS_F_NOADR}, `FCS_HC_OP,
                `FCS_N_NONE, fcs_pkg::K_NONE, fcs_pkg::Q_NONE,
                fcs_pkg::PH_PWREN);
          end
          fcs_pkg::OP_READ:
          begin
            nx.maddr = r.p[0];
            nx = xfer(nx, {`FCS_F_READ, r.p[1][23:0]}, `FCS_HC_ADDR,
              r.p[2], fcs_pkg::K_MEM, fcs_pkg::Q_NONE,
              fcs_pkg::PH_NONE);
          end
          fcs_pkg::OP_APND:
            nx = xfer(nx, {`FCS_F_READ, r.p[0][23:0]}, `FCS_HC_ADDR,
              r.p[1], fcs_pkg::K_DL, fcs_pkg::Q_NONE,
              fcs_pkg::PH_NONE);
          fcs_pkg::OP_UPD:
          begin
            nx.maddr = r.p[1];
            nx.mism = 1'b0;
            nx = xfer(nx, {`FCS_F_READ, r.p[0][23:0]}, `FCS_HC_ADDR,
              r.p[2], fcs_pkg::K_CMP, fcs_pkg::Q_NONE,
              fcs_pkg::PH_CMP);
          end
          fcs_pkg::OP_DET:
          begin
            nx.fst = `FCS_FS_DET;
            nx.oe = 1'b0;
            nx.csn = 1'b1;
          end
          fcs_pkg::OP_ATT:
          begin
            nx.fst = `FCS_FS_BASIC;
            nx.oe = 1'b1;
            nx.csn = 1'b1;
          end
          fcs_pkg::OP_FAST:
            nx = xfer(nx, {`FCS_F_RDID, `FCS_F_NOADR}, `FCS_HC_OP,
              `FCS_ID_LEN, fcs_pkg::K_CAP, fcs_pkg::Q_NONE,
              fcs_pkg::PH_ID);
          fcs_pkg::OP_DSEL:
          begin
            nx.csn = 1'b1;
            nx.oe = r.fst != `FCS_FS_DET;
          end
          fcs_pkg::OP_TX:
          begin
            nx = xfer(nx, `FCS_N_NONE, `FCS_HC_NONE, r.p[0],
              fcs_pkg::K_NONE, fcs_pkg::Q_CMD, fcs_pkg::PH_NONE);
            nx.hold = 1'b1;
            nx.oe = 1'b1;
            nx.tb = 2'h0;
          end
          fcs_pkg::OP_RX:
          begin
            nx.maddr = r.p[0];
            nx = xfer(nx, `FCS_N_NONE, `FCS_HC_NONE, r.p[1],
              fcs_pkg::K_MEM, fcs_pkg::Q_NONE, fcs_pkg::PH_NONE);
            nx.hold = 1'b1;
            nx.oe = 1'b1;
          end
          fcs_pkg::OP_CLR:
          begin
            // A busy display list would render against a cleared cache
            nx.clr = DL_EMPTY_IN;
            nx.flt = !DL_EMPTY_IN;
            nx.pz = !DL_EMPTY_IN;
          end
          fcs_pkg::OP_SRC:
            nx.sptr = r.p[0];
          fcs_pkg::OP_VID:
            nx = xfer(nx, {`FCS_F_READ, r.sptr[23:0]}, `FCS_HC_ADDR,
              `FCS_VHDR_LEN, fcs_pkg::K_VH, fcs_pkg::Q_NONE,
              fcs_pkg::PH_NONE);
          default:
            nx.st = fcs_pkg::S_FIN;
        endcase
      end
      // Retire the finished byte into its sink, then pick the next one
      fcs_pkg::S_NEXT:
      begin
        if (r.dat)
        begin
          nx.n = r.n - `FCS_N_ONE;
          nx.wb = r.sh;
          nx.ma = r.maddr;
          nx.we = r.snk == fcs_pkg::K_MEM;
          nx.dlwe = r.snk == fcs_pkg::K_DL;
          nx.vhv = r.snk == fcs_pkg::K_VH;
          nx.cap = {r.cap[23:0], r.sh};
          if (r.snk == fcs_pkg::K_MEM)
            nx.maddr = r.maddr + `FCS_N_ONE;
          if (r.snk == fcs_pkg::K_CMP && r.sh != r.cmpb)
            nx.mism = 1'b1;
        end
        nx.dat = 1'b0;
        if (r.hc != `FCS_HC_NONE)
        begin
          nx.sh = r.hdr[31:24];
          nx.hdr = {r.hdr[23:0], 8'h00};
          nx.hc = r.hc - 3'h1;
          nx.st = fcs_pkg::S_SHIFT;
        end
        else if (nx.n != `FCS_N_NONE)
        begin
          nx.dat = 1'b1;
          nx.sh = 8'hFF;
          if (r.src == fcs_pkg::Q_CMD)
            nx.st = fcs_pkg::S_TXW;
          else if (r.src == fcs_pkg::Q_MEM || r.snk == fcs_pkg::K_CMP)
          begin
            nx.re = 1'b1;
            nx.ma = r.maddr;
            nx.st = fcs_pkg::S_FETCH;
          end
          else
            nx.st = fcs_pkg::S_SHIFT;
        end
        else
          nx.st = fcs_pkg::S_XEND;
      end
      fcs_pkg::S_FETCH:
        nx.st = fcs_pkg::S_LOAD;
      fcs_pkg::S_LOAD:
      begin
        if (r.src == fcs_pkg::Q_MEM)
          nx.sh = MEM_RDATA_IN;
        else
          nx.cmpb = MEM_RDATA_IN;
        nx.maddr = r.maddr + `FCS_N_ONE;
        nx.st = fcs_pkg::S_SHIFT;
      end
      // Inline bytes go out lowest first; unused bytes of a partial last word are dropped
      fcs_pkg::S_TXW:
        if (r.tb != 2'h0)
        begin
          nx.sh = r.txw[7:0];
          nx.txw = {8'h00, r.txw[31:8]};
          nx.tb = r.tb + 2'h1;
          nx.st = fcs_pkg::S_SHIFT;
        end
        else if (CMD_VALID_IN)
        begin
          nx.sh = CMD_DATA_IN[7:0];
          nx.txw = {8'h00, CMD_DATA_IN[31:8]};
          nx.tb = 2'h1;
          nx.st = fcs_pkg::S_SHIFT;
        end
      // Mode 0 at half the system clock: sample on rise, shift on fall
      fcs_pkg::S_SHIFT:
        if (!r.sclk)
        begin
          nx.sclk = 1'b1;
          nx.rxb = SPI_MISO_IN;
        end
        else
        begin
          nx.sclk = 1'b0;
          nx.sh = {r.sh[6:0], r.rxb};
          nx.bc = r.bc + 3'h1;
          if (r.bc == 3'h7)
            nx.st = fcs_pkg::S_NEXT;
        end
      fcs_pkg::S_XEND:
      begin
        nx.csn = r.csn | !r.hold;
        nx.st = fcs_pkg::S_STEP;
      end
      // Sequencing of multi-transfer operations
      fcs_pkg::S_STEP:
      begin
        nx.st = fcs_pkg::S_FIN;
        case (r.ph)
          fcs_pkg::PH_CMP:
            if (r.mism)
            begin
              nx.faddr = r.p[0];
              nx.rem = r.p[2];
              nx = xfer(nx, {`FCS_F_WREN, `FCS_F_NOADR}, `FCS_HC_OP,
                `FCS_N_NONE, fcs_pkg::K_NONE, fcs_pkg::Q_NONE,
                fcs_pkg::PH_EWREN);
            end
          fcs_pkg::PH_EWREN:
            nx = xfer(nx, {`FCS_F_SE, r.faddr[23:0]}, `FCS_HC_ADDR,
              `FCS_N_NONE, fcs_pkg::K_NONE, fcs_pkg::Q_NONE,
              fcs_pkg::PH_ERASE);
          fcs_pkg::PH_ERASE, fcs_pkg::PH_PAGE:
            nx = xfer(nx, {`FCS_F_RDSR, `FCS_F_NOADR}, `FCS_HC_OP,
              `FCS_N_ONE, fcs_pkg::K_CAP, fcs_pkg::Q_NONE,
              r.ph == fcs_pkg::PH_ERASE ? fcs_pkg::PH_EPOLL
                                        : fcs_pkg::PH_PPOLL);
          fcs_pkg::PH_EPOLL, fcs_pkg::PH_PPOLL:
            if (r.cap[`FCS_WIP_BIT])
              nx = xfer(nx, {`FCS_F_RDSR, `FCS_F_NOADR}, `FCS_HC_OP,
                `FCS_N_ONE, fcs_pkg::K_CAP, fcs_pkg::Q_NONE, r.ph);
            else if (r.ph == fcs_pkg::PH_EPOLL && r.rem == `FCS_SECTOR)
            begin
              nx.faddr = r.p[0];
              nx.maddr = r.p[1];
              nx.rem = r.p[2];
              nx = xfer(nx, {`FCS_F_WREN, `FCS_F_NOADR}, `FCS_HC_OP,
                `FCS_N_NONE, fcs_pkg::K_NONE, fcs_pkg::Q_NONE,
                fcs_pkg::PH_PWREN);
            end
            else if (r.ph == fcs_pkg::PH_EPOLL)
            begin
              nx.faddr = r.faddr + `FCS_SECTOR;
              nx.rem = r.rem - `FCS_SECTOR;
              nx = xfer(nx, {`FCS_F_WREN, `FCS_F_NOADR}, `FCS_HC_OP,
                `FCS_N_NONE, fcs_pkg::K_NONE, fcs_pkg::Q_NONE,
                fcs_pkg::PH_EWREN);
            end
            else if (r.rem != `FCS_PAGE)
            begin
              nx.faddr = r.faddr + `FCS_PAGE;
              nx.rem = r.rem - `FCS_PAGE;
              nx = xfer(nx, {`FCS_F_WREN, `FCS_F_NOADR}, `FCS_HC_OP,
                `FCS_N_NONE, fcs_pkg::K_NONE, fcs_pkg::Q_NONE,
                fcs_pkg::PH_PWREN);
            end
          fcs_pkg::PH_PWREN:
            nx = xfer(nx, {`FCS_F_PP, r.faddr[23:0]}, `FCS_HC_ADDR,
              `FCS_PAGE, fcs_pkg::K_NONE, fcs_pkg::Q_MEM,
              fcs_pkg::PH_PAGE);
          fcs_pkg::PH_ID:
            if (r.cap[23:0] == `FCS_ID_NONE || r.cap[23:0] == 24'h00_0000)
            begin
              nx.rwe = 1'b1;
              nx.res = `FCS_R_NOSUP;
            end
            else
              nx = xfer(nx, {`FCS_F_READ, `FCS_F_NOADR}, `FCS_HC_ADDR,
                `FCS_HDR_LEN, fcs_pkg::K_CAP, fcs_pkg::Q_NONE,
                fcs_pkg::PH_HDR);
          fcs_pkg::PH_HDR:
          begin
            nx.rwe = 1'b1;
            if (r.cap == `FCS_BLANK)
              nx.res = `FCS_R_NOHDR;
            else if (r.cap != `FCS_HDR_MAGIC)
              nx.res = `FCS_R_BADSUM;
            else
            begin
              nx.res = `FCS_R_OK;
              nx.fst = `FCS_FS_FULL;
            end
          end
          default:
            nx.st = fcs_pkg::S_FIN;
        endcase
      end
      // Completion only after all flash and memory traffic is over
      fcs_pkg::S_FIN:
      begin
        nx.done = 1'b1;
        nx.st = fcs_pkg::S_IDLE;
      end
      default:
        nx.st = fcs_pkg::S_IDLE;
    endcase
  end

  // State register; flash starts attached in basic mode
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      r <= '0;
      r.csn <= 1'b1;
      r.oe <= 1'b1;
      r.fst <= `FCS_FS_BASIC;
    end
    else
      r <= nx;
  end

  // Ready is combinational so words are taken in the deciding cycle
  assign CMD_READY_OUT = r.st == fcs_pkg::S_IDLE ||
    r.st == fcs_pkg::S_PARAM || (r.st == fcs_pkg::S_TXW && r.tb == 2'h0);
  assign CMD_DONE_OUT = r.done;
  assign SPI_SCLK_OUT = r.sclk;
  assign SPI_CS_N_OUT = r.csn;
  assign SPI_MOSI_OUT = r.sh[7];
  assign SPI_OE_OUT = r.oe;
  assign MEM_ADDR_OUT = r.ma;
  assign MEM_RE_OUT = r.re;
  assign MEM_WE_OUT = r.we;
  assign RX_BYTE_OUT = r.wb;
  assign DL_WE_OUT = r.dlwe;
  assign VHDR_VALID_OUT = r.vhv;
  assign RESULT_WE_OUT = r.rwe;
  assign RESULT_OUT = r.res;
  assign CACHE_CLR_OUT = r.clr;
  assign FAULT_OUT = r.flt;
  assign PCLK_ZERO_OUT = r.pz;
  assign FLASH_STATE_OUT = r.fst;
  assign SRC_PTR_OUT = r.sptr;

  property p_detach;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (r.st == fcs_pkg::S_DISP && r.op == fcs_pkg::OP_DET) |=>
      (FLASH_STATE_OUT == `FCS_FS_DET && !SPI_OE_OUT) ##1 CMD_DONE_OUT;
  endproperty
  a_detach: assert property (p_detach) else $error("detach failed");
  property p_detgate;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (CMD_READY_OUT && r.st == fcs_pkg::S_IDLE && CMD_VALID_IN &&
     r.fst == `FCS_FS_DET && !det_ok(op_of(CMD_DATA_IN))) |=> ##1
      (CMD_DONE_OUT && FLASH_STATE_OUT == `FCS_FS_DET &&
       SPI_OE_OUT == $past(SPI_OE_OUT, 2));
  endproperty
  a_detgate: assert property (p_detgate) else $error("bad detach cmd");
  property p_attach;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (r.st == fcs_pkg::S_DISP && r.op == fcs_pkg::OP_ATT) |=>
      FLASH_STATE_OUT == `FCS_FS_BASIC && SPI_OE_OUT && SPI_CS_N_OUT;
  endproperty
  a_attach: assert property (p_attach) else $error("attach failed");
  property p_fastok;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (RESULT_WE_OUT && RESULT_OUT == `FCS_R_OK) |->
      FLASH_STATE_OUT == `FCS_FS_FULL && $past(r.cap) == `FCS_HDR_MAGIC;
  endproperty
  a_fastok: assert property (p_fastok) else $error("bad success");
  property p_fastcode;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (RESULT_WE_OUT && RESULT_OUT != `FCS_R_OK) |->
      RESULT_OUT inside {[`FCS_R_NOSUP:`FCS_R_SPEED]} ##1 CMD_DONE_OUT;
  endproperty
  a_fastcode: assert property (p_fastcode) else $error("bad code");
  property p_desel;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (r.st == fcs_pkg::S_DISP && r.op == fcs_pkg::OP_DSEL) |=>
      SPI_CS_N_OUT && !SPI_SCLK_OUT;
  endproperty
  a_desel: assert property (p_desel) else $error("cs still low");
  property p_clear;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (r.st == fcs_pkg::S_DISP && r.op == fcs_pkg::OP_CLR) |=>
      (FAULT_OUT == !$past(DL_EMPTY_IN)) && (PCLK_ZERO_OUT == FAULT_OUT) &&
      (CACHE_CLR_OUT == $past(DL_EMPTY_IN));
  endproperty
  a_clear: assert property (p_clear) else $error("cache clear wrong");
  property p_source;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (r.st == fcs_pkg::S_DISP && r.op == fcs_pkg::OP_SRC) |=>
      SRC_PTR_OUT == $past(r.p[0]);
  endproperty
  a_source: assert property (p_source) else $error("source lost");
  property p_busy;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (r.st == fcs_pkg::S_SHIFT) |-> !CMD_READY_OUT && !CMD_DONE_OUT &&
      !SPI_CS_N_OUT;
  endproperty
  a_busy: assert property (p_busy) else $error("early completion");
endmodule : fcs_sequencer

//--- fcs_defines.svh
// Constants for the flash command sequencer: command codes, result
// codes, serial flash opcodes, sizes and flash state encodings.
// Included by the package users; holds definitions only.
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// Command words taken from the command stream
`define FCS_C_PROG   32'hFFFF_FF70
`define FCS_C_READ   32'hFFFF_FF46
`define FCS_C_APND   32'hFFFF_FF59
`define FCS_C_UPD    32'hFFFF_FF47
`define FCS_C_DET    32'hFFFF_FF48
`define FCS_C_ATT    32'hFFFF_FF49
`define FCS_C_FAST   32'hFFFF_FF4A
`define FCS_C_DSEL   32'hFFFF_FF4B
`define FCS_C_TX     32'hFFFF_FF4C
`define FCS_C_RX     32'hFFFF_FF4D
`define FCS_C_SRC    32'hFFFF_FF4E
`define FCS_C_VID    32'hFFFF_FF5F
// Cache clear code is assigned locally; arbitrary value
`define FCS_C_CLR    32'hFFFF_FF4F
// Result words of the full-speed switch
`define FCS_R_OK     32'h0000_0000
`define FCS_R_NOSUP  32'h0000_E001
`define FCS_R_NOHDR  32'h0000_E002
`define FCS_R_BADSUM 32'h0000_E003
`define FCS_R_MISM   32'h0000_E004
`define FCS_R_SPEED  32'h0000_E005
// Serial flash opcodes
`define FCS_F_READ   8'h03
`define FCS_F_PP     8'h02
`define FCS_F_WREN   8'h06
`define FCS_F_SE     8'h20
`define FCS_F_RDSR   8'h05
`define FCS_F_RDID   8'h9F
`define FCS_F_NOADR  24'h00_0000
`define FCS_WIP_BIT  0
// Header byte counts and transfer lengths
`define FCS_HC_OP    3'h1
`define FCS_HC_ADDR  3'h4
`define FCS_HC_NONE  3'h0
`define FCS_N_NONE   32'h0000_0000
`define FCS_N_ONE    32'h0000_0001
`define FCS_ID_LEN   32'h0000_0003
`define FCS_HDR_LEN  32'h0000_0004
`define FCS_VHDR_LEN 32'h0000_0010
`define FCS_SECTOR   32'h0000_1000
`define FCS_PAGE     32'h0000_0100
`define FCS_ID_NONE  24'hFF_FFFF
`define FCS_BLANK    32'hFFFF_FFFF
// Configuration image marker; arbitrary value
`define FCS_HDR_MAGIC 32'h5A5B_5859
// Flash state encodings
`define FCS_FS_DET   2'h1
`define FCS_FS_BASIC 2'h2
`define FCS_FS_FULL  2'h3
`endif

//--- fcs_pkg.sv
// Types of the flash command sequencer: states, operations, phases and
// the packed state record. No assumptions beyond a SystemVerilog tool.
package fcs_pkg;
  typedef enum logic [3:0] {S_IDLE, S_PARAM, S_DISP, S_NEXT, S_FETCH,
    S_LOAD, S_TXW, S_SHIFT, S_XEND, S_STEP, S_FIN} fcs_st_t;
  typedef enum logic [3:0] {OP_NONE, OP_PROG, OP_READ, OP_APND, OP_UPD,
    OP_DET, OP_ATT, OP_FAST, OP_DSEL, OP_TX, OP_RX, OP_CLR, OP_SRC,
    OP_VID} fcs_op_t;
  typedef enum logic [3:0] {PH_NONE, PH_CMP, PH_EWREN, PH_ERASE, PH_EPOLL,
    PH_PWREN, PH_PAGE, PH_PPOLL, PH_ID, PH_HDR} fcs_ph_t;
  typedef enum logic [2:0] {K_NONE, K_MEM, K_DL, K_CMP, K_CAP,
    K_VH} fcs_snk_t;
  typedef enum logic [1:0] {Q_NONE, Q_MEM, Q_CMD} fcs_src_t;
  typedef struct packed {
    fcs_st_t          st;
    fcs_op_t          op;
    fcs_ph_t          ph;
    fcs_snk_t         snk;
    fcs_src_t         src;
    logic [2:0][31:0] p;
    logic [1:0]       pc;
    logic [1:0]       need;
    logic [31:0]      hdr;
    logic [2:0]       hc;
    logic [31:0]      n;
    logic [31:0]      maddr;
    logic [31:0]      faddr;
    logic [31:0]      rem;
    logic [31:0]      cap;
    logic [31:0]      txw;
    logic [31:0]      res;
    logic [31:0]      sptr;
    logic [31:0]      ma;
    logic [7:0]       sh;
    logic [7:0]       cmpb;
    logic [7:0]       wb;
    logic [2:0]       bc;
    logic [1:0]       tb;
    logic [1:0]       fst;
    logic             sclk;
    logic             rxb;
    logic             csn;
    logic             oe;
    logic             hold;
    logic             dat;
    logic             mism;
    logic             re;
    logic             we;
    logic             dlwe;
    logic             vhv;
    logic             rwe;
    logic             done;
    logic             clr;
    logic             flt;
    logic             pz;
  } fcs_state_t;
endpackage : fcs_pkg

//--- fcs_flash_model.sv
// Serial flash model: mode 0, MSB first, read data is address ^ 5A.
// Assumes the sequencer drives SCLK idle low and owns chip select.
`timescale 1ns/1ps
module fcs_flash_model (
  input  wire logic clk_in,
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic mosi_in,
  input  wire logic id_ok_in,
  output logic      miso_out
);
  logic [7:0]  op, sr, dout;
  logic [23:0] a;
  logic [2:0]  bc = 3'h0;
  int          nb;
  // Each select starts a new opcode
  always @(negedge cs_n_in) nb = 0;
  // Opcode, 24-bit address, then one address step per byte
  always @(posedge sclk_in)
  begin
    sr = {sr[6:0], mosi_in};
    bc = bc + 3'h1;
    if (bc == 3'h0) op = (nb == 0) ? sr : op;
    if (bc == 3'h0) a = (nb == 0) ? a : (nb < 4) ? {a[15:0], sr} : a + 24'h1;
    nb += int'(bc == 3'h0);
  end
  // Shift on the fall so each bit is set up before the next rise;
  // the ID answer is all zeros, an unsupported part, unless enabled
  always @(negedge sclk_in)
    if (bc != 3'h0) dout = {dout[6:0], 1'b0};
    else if (op == 8'h03) dout = a[7:0] ^ 8'h5A;
    else dout = (op == 8'h9F && id_ok_in) ? 8'hC3 : 8'h00;
  // Deselected line follows the clock so stale data never looks valid
  assign miso_out = cs_n_in ? clk_in : dout[7];
endmodule : fcs_flash_model

//--- tb.sv
// Bench for the flash command sequencer: command table, then hand tests.
// Assumes fcs_flash_model on the SPI lines and a byte memory stub here.
`timescale 1ns/1ps
`include "fcs_defines.svh"
module tb;
  typedef struct {logic [31:0] c, p; int n; logic [1:0] st;} fcs_row_t;
  logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, dle = 1'b1, rdy, done;
  logic        miso, sclk, csn, mosi, oe, re, we, vh, fault, pz, dlw, rwe, cc;
  logic        idok = 1'b0;
  logic [31:0] din = 32'h0, addr, res, sptr;
  logic [7:0]  rdata = 8'h00, rxb;
  logic [1:0]  fst;
  int          fails, total_checks, cyc, nw, nv, nf, nd, nc, nr;
  fcs_row_t    rows [7] = '{'{`FCS_C_SRC, 32'h1040, 1, `FCS_FS_BASIC},
    '{`FCS_C_DET, 32'h0, 0, `FCS_FS_DET}, '{`FCS_C_VID, 32'h0, 0, `FCS_FS_DET},
    '{`FCS_C_ATT, 32'h0, 0, `FCS_FS_BASIC}, '{32'hFFFF_FF00, 32'h0, 0, 2'h2},
    '{`FCS_C_PROG, 32'h0, 3, `FCS_FS_BASIC},
    '{`FCS_C_UPD, 32'h0, 3, `FCS_FS_BASIC}};
  fcs_sequencer dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(vld),
    .CMD_DATA_IN(din), .CMD_READY_OUT(rdy), .CMD_DONE_OUT(done),
    .SPI_SCLK_OUT(sclk), .SPI_CS_N_OUT(csn), .SPI_MOSI_OUT(mosi),
    .SPI_OE_OUT(oe), .SPI_MISO_IN(miso), .MEM_ADDR_OUT(addr), .MEM_RE_OUT(re),
    .MEM_WE_OUT(we), .MEM_RDATA_IN(rdata), .RX_BYTE_OUT(rxb), .DL_WE_OUT(dlw),
    .DL_EMPTY_IN(dle), .VHDR_VALID_OUT(vh), .RESULT_WE_OUT(rwe),
    .RESULT_OUT(res), .CACHE_CLR_OUT(cc), .FAULT_OUT(fault),
    .PCLK_ZERO_OUT(pz),
    .FLASH_STATE_OUT(fst), .SRC_PTR_OUT(sptr));
  fcs_flash_model flash (.clk_in(clk), .sclk_in(sclk), .cs_n_in(csn),
    .mosi_in(mosi), .id_ok_in(idok), .miso_out(miso));
  initial forever #10 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    fails += int'(got !== exp);
    if (got !== exp) $display("ERROR %s expected %h seen %h", nm, exp, got);
  endtask : chk
  // Whole command: code then parameters, held until taken
  task automatic cmd(input logic [31:0] w [4], input int n);
    vld <= 1'b1;
    for (int i = 0; i <= n; i++)
    begin
      din <= w[i];
      do @(posedge clk); while (rdy !== 1'b1);
    end
    vld <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
  endtask : cmd
  task automatic wrap_up(input int hung);
    fails += hung;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Memory stub answers one cycle after a read; idle cycles invert data
  always @(posedge clk)
  begin
    rdata <= re ? addr[7:0] : ~rdata;
    nw += int'(we);
    if (we) chk("mem_byte", {24'h0, rxb}, {24'h0, addr[7:0] ^ 8'h5A});
    if (vh) chk("vid_byte", {24'h0, rxb}, {24'h0, 8'h40 + nv[7:0] ^ 8'h5A});
    nv += int'(vh);
    nf += int'(fault & pz);
    if (dlw) chk("dl_byte", {24'h0, rxb},
      {24'h0, 8'h80 + nd[7:0] ^ 8'h5A});
    nd += int'(dlw);
    nc += int'(cc);
    nr += int'(rwe);
    if (++cyc > 40000) wrap_up(1);
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      cmd('{rows[i].c, rows[i].p, 32'h0, 32'h0}, rows[i].n);
      repeat (2) @(posedge clk);
      chk("state", {30'h0, fst}, {30'h0, rows[i].st});
      chk("drive", {31'h0, oe}, {31'h0, rows[i].st != `FCS_FS_DET});
    end
    chk("src_ptr", sptr, 32'h1040);
    cmd('{`FCS_C_VID, 32'h0, 32'h0, 32'h0}, 0);
    chk("vid_count", 32'(nv), 32'h10);
    cmd('{`FCS_C_FAST, 32'h0, 32'h0, 32'h0}, 1);
    chk("result", res, `FCS_R_NOSUP);
    idok <= 1'b1;
    cmd('{`FCS_C_FAST, 32'h0, 32'h0, 32'h0}, 1);
    chk("result", res, `FCS_R_OK);
    chk("state", {30'h0, fst}, {30'h0, `FCS_FS_FULL});
    cmd('{`FCS_C_READ, 32'h140, 32'h40, 32'h4}, 3);
    chk("mem_count", 32'(nw), 32'h4);
    cmd('{`FCS_C_DET, 32'h0, 32'h0, 32'h0}, 0);
    cmd('{`FCS_C_TX, 32'h4, 32'h4000_0003, 32'h0}, 2);
    cmd('{`FCS_C_RX, 32'h240, 32'h2, 32'h0}, 2);
    cmd('{`FCS_C_DSEL, 32'h0, 32'h0, 32'h0}, 0);
    chk("cs_n", {31'h0, csn}, 32'h1);
    chk("drive", {31'h0, oe}, 32'h0);
    chk("rx_count", 32'(nw), 32'h6);
    cmd('{`FCS_C_ATT, 32'h0, 32'h0, 32'h0}, 0);
    cmd('{`FCS_C_APND, 32'h80, 32'h2, 32'h0}, 2);
    chk("dl_count", 32'(nd), 32'h2);
    cmd('{`FCS_C_CLR, 32'h0, 32'h0, 32'h0}, 0);
    dle <= 1'b0;
    cmd('{`FCS_C_CLR, 32'h0, 32'h0, 32'h0}, 0);
    chk("faults", 32'(nf), 32'h1);
    chk("clears", 32'(nc), 32'h1);
    chk("results", 32'(nr), 32'h2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset_src", sptr, 32'h0);
    wrap_up(0);
  end
endmodule : tb
